// ---- hw/msm_top.sv ----
// Purpose: mode latching, mode/map registers and memory-map decode
// Assumes: AXI4-Lite master keeps one read and one write outstanding at most
// Notes: eeprom in the large variant shares read timing with rom
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "msm_map.svh"
module msm_top #(
	parameter int          AW        = 18,
	parameter int          RAM_BYTES = 512,
	parameter logic [15:0] ROM_BASE  = 16'hD000,
	parameter bit          EE_2K     = 1'b0,
	parameter logic [7:0]  CFG_INIT  = `MSM_CFG_RST
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          mode_pin_a_in,
	output logic               mode_pin_a_out,
	output logic               mode_pin_a_oe_n,
	input  wire logic          mode_pin_b_in,
	input  wire logic [15:0]   cpu_addr,
	input  wire logic          cpu_access,
	input  wire logic          cpu_insn_first,
	output logic               sel_regs,
	output logic               sel_ram,
	output logic               sel_boot,
	output logic               sel_eeprom,
	output logic               sel_rom,
	output logic               sel_ext,
	output logic [15:0]        reset_vector,
	output logic               special_mode_flag,
	output logic               mode_select_a_flag,
	output logic               boot_rom_enable,
	output logic               test_access,
	output logic               eclock_off,
	output logic               read_visibility,
	output logic               mode_latched
);
	logic                pin_a;
	logic                pin_b;
	logic                latched_ff;
	logic                boot_ff;
	logic                special_ff;
	logic                mda_ff;
	logic                irv_ff;
	logic [3:0]          psel_ff;
	logic                mda_once_ff;
	logic                irv_once_ff;
	logic [7:0]          init_ff;
	logic                init_once_ff;
	logic [7:0]          cfg_byte_ff;
	logic [7:0]          cfg_latch_ff;
	logic                strobe_ff;
	logic                aw_held_ff;
	logic [AW-1:0]       aw_addr_ff;
	logic                w_held_ff;
	logic [31:0]         w_data_ff;
	logic [3:0]          w_strb_ff;
	logic                bvalid_ff;
	logic [1:0]          bresp_ff;
	logic                rvalid_ff;
	logic [31:0]         rdata_ff;
	logic [1:0]          rresp_ff;
	logic                wr_go;
	logic                wr_lane;
	logic [7:0]          wr_byte;
	logic                wr_prio;
	logic                wr_init;
	logic                wr_cfg;
	logic                wr_hit;
	logic                rd_go;
	logic [15:0]         rd_idx;
	logic [15:0]         wr_idx;
	logic [7:0]          prio_view;
	logic [7:0]          nxt_rdata;
	logic                nxt_rhit;
	msm_pkg::msm_mode_t  mode;
	msm_pkg::msm_mode_t  pin_mode;

	msm_dec_if dec_bus ();

	msm_sync sync_a (
		.clock (clock),
		.pin   (mode_pin_a_in),
		.level (pin_a)
	);

	msm_sync sync_b (
		.clock (clock),
		.pin   (mode_pin_b_in),
		.level (pin_b)
	);

	// mode from the pins, used only at the latch edge
	always_comb begin
		unique case ({pin_b, pin_a})
			2'b10:   pin_mode = msm_pkg::msm_single; // R8
			2'b11:   pin_mode = msm_pkg::msm_expand; // R8
			2'b00:   pin_mode = msm_pkg::msm_boot; // R8
			2'b01:   pin_mode = msm_pkg::msm_test; // R8
		endcase
	end

	// running mode follows the flags alone
	always_comb begin
		unique case ({special_ff, mda_ff})
			2'b00:   mode = msm_pkg::msm_single; // R9
			2'b01:   mode = msm_pkg::msm_expand; // R9
			2'b10:   mode = msm_pkg::msm_boot; // R9
			2'b11:   mode = msm_pkg::msm_test; // R9
		endcase
	end

	// axi write channel
	always_comb begin
		wr_go   = aw_held_ff && w_held_ff && !bvalid_ff;
		wr_idx  = aw_addr_ff[AW-1:2];
		wr_lane = w_strb_ff[0];
		wr_byte = w_data_ff[7:0];
		wr_prio = wr_go && wr_lane && (wr_idx == `MSM_IDX_PRIO);
		wr_init = wr_go && wr_lane && (wr_idx == `MSM_IDX_INIT);
		wr_cfg  = wr_go && wr_lane && (wr_idx == `MSM_IDX_CFG);
		wr_hit  = (wr_idx == `MSM_IDX_PRIO) || (wr_idx == `MSM_IDX_INIT)
			|| (wr_idx == `MSM_IDX_CFG) || (wr_idx == `MSM_IDX_STAT);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			w_held_ff <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `MSM_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? `MSM_RESP_OKAY : `MSM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// mode latch on the first edge after reset release
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			latched_ff <= 1'b0;
		end else begin
			latched_ff <= 1'b1;
		end
	end

	// priority/miscellaneous register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			boot_ff     <= 1'b0;
			special_ff  <= 1'b0;
			mda_ff      <= 1'b0;
			irv_ff      <= 1'b0;
			psel_ff     <= `MSM_PSEL_RST;
			mda_once_ff <= 1'b0;
			irv_once_ff <= 1'b0;
		end else if (!latched_ff) begin
			special_ff <= !pin_b; // R7 R16
			mda_ff     <= pin_a; // R7 R16
			boot_ff    <= (pin_mode == msm_pkg::msm_boot); // R14
			irv_ff     <= (pin_mode == msm_pkg::msm_test); // R14
			psel_ff    <= `MSM_PSEL_RST; // R14
		end else if (wr_prio) begin
			psel_ff <= wr_byte[3:0]; // R13
			if (special_ff) begin
				boot_ff <= wr_byte[`MSM_PRIO_BOOT]; // R18
				mda_ff  <= wr_byte[`MSM_PRIO_MDA]; // R17
			end else if (!mda_once_ff) begin
				mda_ff      <= wr_byte[`MSM_PRIO_MDA]; // R17
				mda_once_ff <= 1'b1;
			end
			// special flag may be cleared, never set
			special_ff <= special_ff && wr_byte[`MSM_PRIO_SPECIAL]; // R17
			// read-visibility bit takes one write in any mode
			if (!irv_once_ff) begin
				irv_ff      <= wr_byte[`MSM_PRIO_IRV];
				irv_once_ff <= 1'b1;
			end
		end
	end

	// ram and register placement, write once outside special modes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			init_ff      <= `MSM_INIT_RST;
			init_once_ff <= 1'b0;
		end else if (wr_init && (special_ff || !init_once_ff)) begin
			init_ff      <= wr_byte;
			init_once_ff <= 1'b1;
		end
	end

	// option byte, reset to CFG_INIT and written in any mode; its working latches, loaded at reset exit and by option byte writes in special modes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_byte_ff <= CFG_INIT;
		end else if (wr_cfg) begin
			cfg_byte_ff <= wr_byte;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_latch_ff <= '0;
		end else if (!latched_ff) begin
			cfg_latch_ff <= cfg_byte_ff;
			if (pin_mode == msm_pkg::msm_single || pin_mode == msm_pkg::msm_boot) begin
				cfg_latch_ff[`MSM_CFG_PROGRAM_ROM_ENABLE] <= 1'b1; // R4
			end
		end else if (wr_cfg && special_ff) begin
			cfg_latch_ff <= wr_byte;
		end
	end

	// axi read channel
	always_comb begin
		rd_go     = s_axi_arvalid && s_axi_arready;
		rd_idx    = s_axi_araddr[AW-1:2];
		prio_view = {boot_ff, special_ff, mda_ff, irv_ff, psel_ff}; // R13
		nxt_rhit  = 1'b1;
		unique case (rd_idx)
			`MSM_IDX_PRIO: nxt_rdata = prio_view;
			`MSM_IDX_INIT: nxt_rdata = init_ff;
			`MSM_IDX_CFG:  nxt_rdata = cfg_latch_ff;
			`MSM_IDX_STAT: nxt_rdata = {3'h0, latched_ff, mode};
			default: begin
				nxt_rdata = 8'h00;
				nxt_rhit  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= `MSM_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h000000, nxt_rdata};
			rresp_ff  <= nxt_rhit ? `MSM_RESP_OKAY : `MSM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// instruction-load strobe on the shared mode-A pin
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= latched_ff && cpu_insn_first; // R10
		end
	end

	// map settings to the decoder
	always_comb begin
		dec_bus.addr      = cpu_addr;
		dec_bus.access    = cpu_access && latched_ff;
		dec_bus.reg_page  = init_ff[3:0];
		dec_bus.ram_page  = init_ff[7:4];
		dec_bus.boot_on   = boot_ff && special_ff; // R2 R18
		dec_bus.ee_on     = cfg_latch_ff[`MSM_CFG_EEON];
		dec_bus.ee_window = EE_2K ? cfg_latch_ff[7:4] : 4'hF; // R6
		dec_bus.rom_on    = cfg_latch_ff[`MSM_CFG_PROGRAM_ROM_ENABLE]; // R3
	end

	msm_decode #(
		.RAM_BYTES (RAM_BYTES),
		.ROM_BASE  (ROM_BASE),
		.EE_2K     (EE_2K)
	) decode (
		.dec (dec_bus)
	);

	assign s_axi_awready      = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready       = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid       = bvalid_ff;
	assign s_axi_bresp        = bresp_ff;
	assign s_axi_arready      = !rvalid_ff;
	assign s_axi_rvalid       = rvalid_ff;
	assign s_axi_rdata        = rdata_ff;
	assign s_axi_rresp        = rresp_ff;
	assign mode_pin_a_out     = 1'b0;
	assign mode_pin_a_oe_n    = !strobe_ff; // R10
	assign sel_regs           = dec_bus.sel.regs;
	assign sel_ram            = dec_bus.sel.ram;
	assign sel_boot           = dec_bus.sel.boot;
	assign sel_eeprom         = dec_bus.sel.eeprom;
	assign sel_rom            = dec_bus.sel.rom;
	assign sel_ext            = dec_bus.sel.ext;
	assign reset_vector       = special_ff ? `MSM_VEC_SPECIAL : `MSM_VEC_NORMAL; // R11 R12
	assign special_mode_flag  = special_ff;
	assign mode_select_a_flag = mda_ff;
	assign boot_rom_enable    = boot_ff;
	assign test_access        = special_ff; // R12
	assign eclock_off         = irv_ff && !mda_ff;
	assign read_visibility    = irv_ff && mda_ff;
	assign mode_latched       = latched_ff;
endmodule

// ---- common/msm_map.svh ----
// Purpose: offsets, field positions, reset values of the mode/map block
// Assumes: register indices are kept as printed; byte address is index times four
// Notes: included by the top module and the decoder
//
// How it works
// R1: registers beat RAM, RAM beats ROM
// R2: boot ROM at BF00-BFFF, bootstrap only; test mode also maps it once a priority write sets bit 7
// R3: expanded modes: program ROM needs enable bit
// R4: single-chip, bootstrap: program ROM always on; in bootstrap an option byte write can clear it
// R5: small EEPROM fixed at B600-B7FF
// R6: large EEPROM default F800, window-select relocates
// R7: two mode pins pick four modes
// R8: pin pairs decode to fixed flag sets
// R9: after reset only latched flags count
// R10: mode-A pin is open-drain instruction strobe
// R11: normal modes vector from FFFA-FFFF
// R12: special modes vector BFFA, test access
// R13: priority register layout at 103C
// R14: priority select resets 0110; upper per mode
// R15: system holds reset while main supply low
// R16: flags load from inverted B and A
// R17: flag write limits in normal modes
// R18: boot enable needs special flag
// R19: one resource selected per access, combinationally
`ifndef MSM_MAP_SVH
`define MSM_MAP_SVH
`define MSM_IDX_PRIO      16'h103C
`define MSM_IDX_INIT      16'h103D
`define MSM_IDX_CFG       16'h103F
`define MSM_IDX_STAT      16'h1040
`define MSM_PRIO_BOOT     7
`define MSM_PRIO_SPECIAL  6
`define MSM_PRIO_MDA      5
`define MSM_PRIO_IRV      4
`define MSM_PSEL_RST      4'h6
`define MSM_INIT_RST      8'h01
`define MSM_CFG_RST       8'hFF
`define MSM_CFG_PROGRAM_ROM_ENABLE     1
`define MSM_CFG_EEON      0
`define MSM_BOOT_BASE     16'hBF00
`define MSM_BOOT_LAST     16'hBFFF
`define MSM_EE512_BASE    16'hB600
`define MSM_EE512_LAST    16'hB7FF
`define MSM_EE2K_LOW      12'h800
`define MSM_REG_SPAN      12'h040
`define MSM_VEC_NORMAL    16'hFFFA
`define MSM_VEC_SPECIAL   16'hBFFA
`define MSM_RESP_OKAY     2'h0
`define MSM_RESP_SLVERR   2'h2
`endif

// ---- common/msm_pkg.sv ----
// Purpose: types shared by the mode/map block
// Assumes: nothing
// Notes: modes are one-hot
package msm_pkg;
	typedef enum logic [3:0] {
		msm_single  = 4'h1,
		msm_expand  = 4'h2,
		msm_boot    = 4'h4,
		msm_test    = 4'h8
	} msm_mode_t;

	typedef struct packed {
		logic regs;
		logic ram;
		logic boot;
		logic eeprom;
		logic rom;
		logic ext;
	} msm_sel_t;
endpackage

// ---- common/msm_dec_if.sv ----
// Purpose: carries map settings to the address decoder and selects back
// Assumes: one clock domain, purely combinational path
// Notes: none
`timescale 1ns/100ps
interface msm_dec_if;
	logic [15:0]        addr;
	logic               access;
	logic [3:0]         reg_page;
	logic [3:0]         ram_page;
	logic               boot_on;
	logic               ee_on;
	logic [3:0]         ee_window;
	logic               rom_on;
	msm_pkg::msm_sel_t  sel;

	modport ctl (output addr, access, reg_page, ram_page, boot_on, ee_on, ee_window, rom_on,
		input sel);
	modport dec (input addr, access, reg_page, ram_page, boot_on, ee_on, ee_window, rom_on,
		output sel);
endinterface

// ---- hw/msm_sync.sv ----
// Purpose: two-flop synchroniser for a pin level
// Assumes: pin is asynchronous to clock
// Notes: left unreset so it follows the pin while reset is held
`timescale 1ns/100ps
module msm_sync (
	input  wire logic clock,
	input  wire logic pin,
	output logic      level
);
	logic meta_ff;
	logic level_ff;

	always_ff @(posedge clock) begin
		meta_ff  <= pin;
		level_ff <= meta_ff;
	end

	assign level = level_ff;
endmodule

// ---- hw/msm_decode.sv ----
// Purpose: resolves an access address to one on-chip resource or the external bus
// Assumes: settings are stable during the access
// Notes: fixed priority, single select
`timescale 1ns/100ps
`include "msm_map.svh"
module msm_decode #(
	parameter int          RAM_BYTES = 512,
	parameter logic [15:0] ROM_BASE  = 16'hD000,
	parameter bit          EE_2K     = 1'b0
) (
	msm_dec_if.dec dec
);
	logic hit_reg;
	logic hit_ram;
	logic hit_boot;
	logic hit_ee;
	logic hit_rom;

	always_comb begin
		hit_reg  = (dec.addr[15:12] == dec.reg_page) && (dec.addr[11:0] < `MSM_REG_SPAN);
		hit_ram  = (dec.addr[15:12] == dec.ram_page) && ({4'h0, dec.addr[11:0]} < 16'(RAM_BYTES));
		hit_boot = dec.boot_on && (dec.addr >= `MSM_BOOT_BASE) && (dec.addr <= `MSM_BOOT_LAST); // R2
		if (EE_2K) begin
			hit_ee = dec.ee_on && (dec.addr[15:12] == dec.ee_window)
				&& (dec.addr[11:0] >= `MSM_EE2K_LOW); // R6
		end else begin
			hit_ee = dec.ee_on && (dec.addr >= `MSM_EE512_BASE)
				&& (dec.addr <= `MSM_EE512_LAST); // R5
		end
		hit_rom  = dec.rom_on && (dec.addr >= ROM_BASE);
		dec.sel  = '0;
		if (dec.access) begin
			if (hit_reg) begin
				dec.sel.regs = 1'b1; // R1 R19
			end else if (hit_ram) begin
				dec.sel.ram = 1'b1; // R1
			end else if (hit_boot) begin
				dec.sel.boot = 1'b1;
			end else if (hit_ee) begin
				dec.sel.eeprom = 1'b1;
			end else if (hit_rom) begin
				dec.sel.rom = 1'b1; // R1
			end else begin
				dec.sel.ext = 1'b1;
			end
		end
	end
endmodule

// ---- sim/msm_chk.sv ----
// Purpose: concurrent checks on the mode/map top ports
// Assumes: default map parameters, register page left at 1
// Notes: bound to the top module from tb_top
`timescale 1ns/100ps
module msm_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        s_axi_bvalid,
	input wire logic        mode_pin_a_in,
	input wire logic        mode_pin_a_out,
	input wire logic        mode_pin_a_oe_n,
	input wire logic        mode_pin_b_in,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_access,
	input wire logic        cpu_insn_first,
	input wire logic        sel_regs,
	input wire logic        sel_ram,
	input wire logic        sel_boot,
	input wire logic        sel_eeprom,
	input wire logic        sel_rom,
	input wire logic        sel_ext,
	input wire logic [15:0] reset_vector,
	input wire logic        special_mode_flag,
	input wire logic        mode_select_a_flag,
	input wire logic        boot_rom_enable,
	input wire logic        mode_latched
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [5:0] sels;
	assign sels = {sel_regs, sel_ram, sel_boot, sel_eeprom, sel_rom, sel_ext};

	a_sel_single: assert property (cpu_access && mode_latched |-> $onehot(sels))
		else $error("access select not one-hot");
	a_sel_idle: assert property (!cpu_access |-> sels == 6'h00)
		else $error("select without access");
	a_boot_window: assert property (sel_boot |->
		cpu_addr[15:8] == 8'hBF && special_mode_flag && boot_rom_enable)
		else $error("boot rom selected outside its window or mode");
	a_rom_forced: assert property (cpu_access && mode_latched && !special_mode_flag &&
		!mode_select_a_flag && cpu_addr >= 16'hE000 |-> sel_rom)
		else $error("program rom off in single-chip");
	a_flag_load: assert property ($rose(mode_latched) |-> special_mode_flag == !mode_pin_b_in
		&& mode_select_a_flag == mode_pin_a_in
		&& boot_rom_enable == (!mode_pin_b_in && !mode_pin_a_in))
		else $error("mode flags not loaded from pins");
	a_vec_mode: assert property ($rose(mode_latched) |->
		##1 reset_vector == (special_mode_flag ? 16'hBFFA : 16'hFFFA))
		else $error("reset vector does not follow mode");
	a_pins_ignored: assert property ($past(mode_latched) &&
		$changed({special_mode_flag, mode_select_a_flag}) |-> $rose(s_axi_bvalid))
		else $error("mode flags moved without a write");
	a_special_mode_flag_sticky: assert property ($past(mode_latched) && !$past(special_mode_flag)
		|-> !special_mode_flag)
		else $error("special flag set again");
	a_strobe_low: assert property (mode_latched && cpu_insn_first |=> !mode_pin_a_oe_n)
		else $error("strobe missing after first cycle");
	a_strobe_high: assert property (!cpu_insn_first |=> mode_pin_a_oe_n)
		else $error("strobe without first cycle");
	a_pin_drain: assert property (mode_pin_a_out == 1'b0)
		else $error("mode pin driven high");
endmodule

// ---- sim/tb_top.sv ----
// Purpose: register, decode and strobe checks of the mode/map block
// Assumes: option byte starts with program rom bit clear
// Notes: one pass per mode pin pair
`timescale 1ns/100ps
module tb_top;
	logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        pa, pb, pa_out, pa_oe_n, access, first, latched, tacc, eoff, rvis;
	logic [15:0] addr, vec;
	logic [5:0]  sels;
	logic [1:0]  pins [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
	logic [7:0]  prio [4] = '{8'h06, 8'h26, 8'hC6, 8'h76};
	logic [7:0]  stat [4] = '{8'h11, 8'h12, 8'h14, 8'h18};
	int          miscompares, comparisons;

	msm_top #(.CFG_INIT(8'hFD)) dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mode_pin_a_in(pa),
		.mode_pin_a_out(pa_out), .mode_pin_a_oe_n(pa_oe_n), .mode_pin_b_in(pb),
		.cpu_addr(addr), .cpu_access(access), .cpu_insn_first(first),
		.sel_regs(sels[5]), .sel_ram(sels[4]), .sel_boot(sels[3]), .sel_eeprom(sels[2]),
		.sel_rom(sels[1]), .sel_ext(sels[0]), .reset_vector(vec), .special_mode_flag(),
		.mode_select_a_flag(), .boot_rom_enable(), .test_access(tacc), .eclock_off(eoff),
		.read_visibility(rvis), .mode_latched(latched));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clock);
			if (awvalid && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (!bvalid);
		bready <= 1'b0;
		check(bresp, r);
	endtask

	task automatic axi_rd(input logic [17:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		rready <= 1'b0;
		check(rdata, {24'h0, d});
		check(rresp, r);
	endtask

	task automatic dec(input logic [15:0] a, input logic [5:0] s);
		@(posedge clock);
		addr <= a;
		access <= 1'b1;
		@(negedge clock);
		check(sels, s);
	endtask

	task automatic boot_up(input logic b, input logic a);
		@(posedge clock);
		rst <= 1'b1;
		pb <= b;
		pa <= a;
		repeat (6) @(posedge clock);
		check(pa_oe_n, 1'b1);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		pb <= !b;
		pa <= !a;
	endtask

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready, pa, pb, access, first} = 10'h200;
		awaddr = 18'h0;
		araddr = 18'h0;
		wdata = 32'h0;
		addr = 16'h0;
		for (int i = 0; i < 4; i++) begin
			boot_up(pins[i][1], pins[i][0]);
			axi_rd(18'h040F0, prio[i], 2'h0);
			axi_rd(18'h04100, stat[i], 2'h0);
			check(vec, i >= 2 ? 16'hBFFA : 16'hFFFA);
			check(tacc, i >= 2);
			check({eoff, rvis}, i == 3 ? 2'b01 : 2'b00);
			dec(16'hBF10, i == 2 ? 6'h08 : 6'h01);
			dec(16'hE000, i[0] ? 6'h01 : 6'h02);
			dec(16'hB600, 6'h04);
			dec(16'hB800, 6'h01);
			dec(16'h103F, 6'h20);
			dec(16'h01FF, 6'h10);
			@(posedge clock);
			first <= 1'b1;
			@(posedge clock);
			first <= 1'b0;
			@(negedge clock);
			check(pa_oe_n, 1'b0);
			axi_rd(18'h040F0, prio[i], 2'h0);
			if (i == 0) begin
				axi_wr(18'h040F4, 8'hD1, 2'h0);
				dec(16'hD000, 6'h10);
				dec(16'hD200, 6'h02);
				axi_wr(18'h040F0, 8'hE6, 2'h0);
				axi_rd(18'h040F0, 8'h26, 2'h0);
				axi_wr(18'h040F0, 8'h06, 2'h0);
				axi_rd(18'h040F0, 8'h26, 2'h0);
			end
			if (i == 2) begin
				axi_wr(18'h040F0, 8'h56, 2'h0);
				axi_rd(18'h040F0, 8'h56, 2'h0);
				dec(16'hBF10, 6'h01);
				check({eoff, rvis}, 2'b10);
			end
			if (i == 3) begin
				axi_wr(18'h040F4, 8'h11, 2'h0);
				dec(16'h1000, 6'h20);
				dec(16'h1040, 6'h10);
				axi_wr(18'h040F0, 8'h34, 2'h0);
				axi_wr(18'h040F0, 8'h74, 2'h0);
				axi_rd(18'h040F0, 8'h34, 2'h0);
			end
		end
		axi_wr(18'h04200, 8'h5A, 2'h2);
		axi_rd(18'h04200, 8'h00, 2'h2);
		results();
	end

	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		results();
	end
endmodule

bind msm_top msm_chk chk (.clock(clock), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
	.mode_pin_a_in(mode_pin_a_in), .mode_pin_a_out(mode_pin_a_out),
	.mode_pin_a_oe_n(mode_pin_a_oe_n), .mode_pin_b_in(mode_pin_b_in), .cpu_addr(cpu_addr),
	.cpu_access(cpu_access), .cpu_insn_first(cpu_insn_first), .sel_regs(sel_regs),
	.sel_ram(sel_ram), .sel_boot(sel_boot), .sel_eeprom(sel_eeprom), .sel_rom(sel_rom),
	.sel_ext(sel_ext), .reset_vector(reset_vector), .special_mode_flag(special_mode_flag),
	.mode_select_a_flag(mode_select_a_flag), .boot_rom_enable(boot_rom_enable),
	.mode_latched(mode_latched));
